// >>> hdl/pma_regs.svh
`ifndef PMA_REGS_SVH
`define PMA_REGS_SVH

// Byte offsets of the management register window
`define PMA_OFS_CTRL_LO     12'h510
`define PMA_OFS_CTRL_HI     12'h511
`define PMA_OFS_PHY_ADDR    12'h512
`define PMA_OFS_REG_IDX     12'h513
`define PMA_OFS_DATA_LO     12'h514
`define PMA_OFS_DATA_HI     12'h515
`define PMA_OFS_FB_OWN      12'h516
`define PMA_OFS_LH_OWN      12'h517
`define PMA_OFS_PORT_STAT   12'h518

// Field positions inside the control word (16 bit view), plus address select bit 7 of port address and force bit 1 of host ownership
`define PMA_BIT_WR_EN       0
`define PMA_BIT_HOST_CAP    1
`define PMA_BIT_LINK_DET    2
`define PMA_BIT_RD_ERR      13
`define PMA_BIT_CMD_ERR     14
`define PMA_BIT_BUSY        15
`define PMA_BIT_ADDR_SEL    7
`define PMA_BIT_FORCE_FB    1

// Command codes
`define PMA_CMD_IDLE        2'h0
`define PMA_CMD_READ        2'h1
`define PMA_CMD_WRITE       2'h2

// Reset values
`define PMA_RST_BYTE        8'h00
`define PMA_RST_WORD        16'h0000

// Management frame layout, in bit slots of one frame
`define PMA_FRAME_LAST      6'd63
`define PMA_TA_FIRST        6'd46
`define PMA_TA_LAST         6'd47
`define PMA_DATA_FIRST      6'd48
`define PMA_STATUS_REG      5'h01

// Timing: clock period, least management clock half period, poll period
`define PMA_CLK_PERIOD_NS   50
`define PMA_MDC_HALF_NS     200
`define PMA_POLL_TIME_NS    1000000
`define PMA_MDC_HALF_CYC    \
    ((`PMA_MDC_HALF_NS + `PMA_CLK_PERIOD_NS - 1) / `PMA_CLK_PERIOD_NS)
`define PMA_POLL_CYC        (`PMA_POLL_TIME_NS / `PMA_CLK_PERIOD_NS)

`endif

// >>> hdl/pma_pkg.sv
`default_nettype none

package pma_pkg;
    typedef logic [1:0] pma_cmd_t;
    typedef logic [4:0] pma_phy_t;
    typedef enum logic [0:0] {
        PMA_IDLE,
        PMA_RUN
    } pma_state_e;
endpackage : pma_pkg

`default_nettype wire

// >>> hdl/pma_top.sv
// What this block does
// - Command field 00 idles and clears errors, 01 reads, 10 writes.
// - Command field reads current command, self-clears when busy drops.
// - Bit 15 is 1 while the management engine runs a command.
// - Write enable clears on next frame start or on any local host write.
// - Write enable reads 1 whenever the local host owns the port.
// - Bit 1 reports whether the local host may take control.
// - Bit 2 reports whether automatic link detection is active.
// - Bits 7:3 show port 0 address or selected port address.
// - Bit 13 sets on failed read, cleared by writing control register.
// - Bit 14 sets on invalid command or write without write enable.
// - Valid command clears bit 14; command 00 clears bits 14 and 13.
// - While busy, writes to control, address, index, data are ignored.
// - Only the current owner side may write management registers.
// - Register index bits 4:0 select the transceiver register.
// - Reserved command code 11 is treated as an invalid command.
// - Fieldbus ownership 0 allows host takeover, 1 claims exclusive use.
// - Fieldbus ownership is writable only while host ownership is 0.
// - Host ownership bit 0 selects owner: 0 fieldbus, 1 local host.
// - Fieldbus writing 1 to host ownership bit 1 forces bit 0 to 0.
// - Port status bit 0 mirrors transceiver status bit 1.2.
// - Port status bit 1 means 100 Mbit/s full duplex, autoneg done.
// - Port status bit 2 flags a link error and inhibits the link.
// - Port status bit 3 latches poll read errors, clears on write.
`include "pma_regs.svh"
`default_nettype none

module pma_top
    import pma_pkg::*;
#(
    parameter int NPORT       = 4,
    parameter int POLL_CYCLES = `PMA_POLL_CYC
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             fm_wr,
    input  wire logic             fm_rd,
    input  wire logic [11:0]      fm_addr,
    input  wire logic [7:0]       fm_wdata,
    output logic      [7:0]       fm_rdata,
    input  wire logic             lh_wr,
    input  wire logic             lh_rd,
    input  wire logic [11:0]      lh_addr,
    input  wire logic [7:0]       lh_wdata,
    output logic      [7:0]       lh_rdata,
    input  wire logic             frame_start,
    input  wire logic             host_ctrl_allowed,
    input  wire logic             link_detect_en,
    input  wire logic [4:0]       port0_phy_addr,
    output logic                  mdc,
    input  wire logic             mdio_i,
    output logic                  mdio_o,
    output logic                  mdio_oe,
    output logic [NPORT-1:0]      port_link_up,
    output logic [NPORT-1:0]      port_link_inhibit
);

    localparam logic [7:0] MDC_HALF = 8'(`PMA_MDC_HALF_CYC);
    localparam int         PW       = (NPORT > 1) ? $clog2(NPORT) : 1;

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic        wr_en_r;
    pma_cmd_t    cmd_r;
    logic        rd_err_r;
    logic        cmd_err_r;
    logic [7:0]  phy_addr_r;
    logic [7:0]  reg_idx_r;
    logic [15:0] data_r;
    logic        fb_own_r;
    logic        lh_own_r;
    logic [NPORT-1:0] st_phys_r;
    logic [NPORT-1:0] st_ok_r;
    logic [NPORT-1:0] st_err_r;
    logic [NPORT-1:0] st_rderr_r;

    // Engine state
    pma_state_e  state_r;
    logic        kind_cmd_r;
    logic        kind_wr_r;
    logic [PW-1:0] kind_port_r;
    logic [7:0]  div_r;
    logic        mdc_r;
    logic [5:0]  bit_r;
    logic [63:0] tx_r;
    logic [15:0] rx_r;
    logic        ta_err_r;
    logic        oe_r;
    logic        done_r;
    logic [31:0] poll_tmr_r;
    logic        poll_due_r;
    logic [PW-1:0] poll_port_r;

    ////////////////////////////////////////////////////////////////////////
    // Derived controls

    logic        busy;
    logic        wr_en_eff;
    logic        own_wr;
    logic [11:0] own_addr;
    logic [7:0]  own_wdata;
    logic        mgmt_wr;
    logic        stat_wr;
    logic        cmd_issue;
    pma_cmd_t    cmd_code;
    logic        eng_start_cmd;
    logic        eng_start_poll;
    logic        mdc_tick;
    logic [4:0]  shown_addr;
    logic [4:0]  target_phy;

    assign busy      = (cmd_r != `PMA_CMD_IDLE);
    assign wr_en_eff = wr_en_r | lh_own_r;

    // The owner's write strobe is the only one reaching the command set
    assign own_wr    = lh_own_r ? lh_wr : fm_wr;
    assign own_addr  = lh_own_r ? lh_addr : fm_addr;
    assign own_wdata = lh_own_r ? lh_wdata : fm_wdata;

    // Writes to 0x510..0x515 are dropped while a command is running
    assign mgmt_wr   = own_wr && !busy &&
                       own_addr >= `PMA_OFS_CTRL_LO &&
                       own_addr <= `PMA_OFS_DATA_HI;
    assign stat_wr   = own_wr &&
                       own_addr >= `PMA_OFS_PORT_STAT &&
                       own_addr < (`PMA_OFS_PORT_STAT + 12'(NPORT));
    assign cmd_issue = mgmt_wr && own_addr == `PMA_OFS_CTRL_HI;
    assign cmd_code  = own_wdata[1:0];

    // Port x sits at port 0 address plus x
    assign shown_addr = phy_addr_r[`PMA_BIT_ADDR_SEL] ?
                        5'(port0_phy_addr + {3'h0, phy_addr_r[1:0]}) :
                        port0_phy_addr;
    assign target_phy = phy_addr_r[4:0];

    // Commands take precedence over polling when both are waiting
    assign eng_start_cmd  = (state_r == PMA_IDLE) && busy && !done_r;
    assign eng_start_poll = (state_r == PMA_IDLE) && !busy && !done_r &&
                            poll_due_r && link_detect_en;
    assign mdc_tick       = (div_r == MDC_HALF - 8'h01);

    ////////////////////////////////////////////////////////////////////////
    // Register read mux, shared by both sides

    function automatic logic [7:0] rd_byte(input logic [11:0] a);
        logic [7:0] v;
        int         p;
        v = 8'h00;
        p = 0;
        unique case (a)
            `PMA_OFS_CTRL_LO: v = {shown_addr,
                                   link_detect_en,
                                   host_ctrl_allowed,
                                   wr_en_eff};
            `PMA_OFS_CTRL_HI: v = {busy, cmd_err_r, rd_err_r,
                                   3'h0, cmd_r};
            `PMA_OFS_PHY_ADDR: v = phy_addr_r;
            `PMA_OFS_REG_IDX:  v = reg_idx_r;
            `PMA_OFS_DATA_LO:  v = data_r[7:0];
            `PMA_OFS_DATA_HI:  v = data_r[15:8];
            `PMA_OFS_FB_OWN:   v = {7'h00, fb_own_r};
            `PMA_OFS_LH_OWN:   v = {7'h00, lh_own_r};
            default: begin
                if (a >= `PMA_OFS_PORT_STAT &&
                    a < (`PMA_OFS_PORT_STAT + 12'(NPORT))) begin
                    p = int'(a - `PMA_OFS_PORT_STAT);
                    v = {4'h0, st_rderr_r[p], st_err_r[p],
                         st_ok_r[p], st_phys_r[p]};
                end
            end
        endcase
        return v;
    endfunction

    // Registered read data, one cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fm_rdata <= `PMA_RST_BYTE;
            lh_rdata <= `PMA_RST_BYTE;
        end else begin
            if (fm_rd) fm_rdata <= rd_byte(fm_addr);
            if (lh_rd) lh_rdata <= rd_byte(lh_addr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ownership

    // Fieldbus may only change its claim while the host does not own
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fb_own_r <= 1'b0;
        end else if (fm_wr && fm_addr == `PMA_OFS_FB_OWN && !lh_own_r) begin
            fb_own_r <= fm_wdata[0];
        end
    end

    // Force from the fieldbus side wins over a host claim
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lh_own_r <= 1'b0;
        end else if (fm_wr && fm_addr == `PMA_OFS_LH_OWN &&
                     fm_wdata[`PMA_BIT_FORCE_FB]) begin
            lh_own_r <= 1'b0;
        end else if (lh_wr && lh_addr == `PMA_OFS_LH_OWN) begin
            // Takeover only when offered and when capability exists
            if (!lh_wdata[0])
                lh_own_r <= 1'b0;
            else if (!fb_own_r && host_ctrl_allowed)
                lh_own_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write enable

    // Host accesses end in one cycle, so its write ends the grant
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_en_r <= 1'b0;
        end else if (frame_start || lh_wr) begin
            wr_en_r <= 1'b0;
        end else if (!lh_own_r && mgmt_wr &&
                     own_addr == `PMA_OFS_CTRL_LO) begin
            wr_en_r <= own_wdata[`PMA_BIT_WR_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address, index and data registers

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phy_addr_r <= `PMA_RST_BYTE;
            reg_idx_r  <= `PMA_RST_BYTE;
        end else if (mgmt_wr) begin
            if (own_addr == `PMA_OFS_PHY_ADDR)
                phy_addr_r <= {own_wdata[7], 2'h0, own_wdata[4:0]};
            if (own_addr == `PMA_OFS_REG_IDX)
                reg_idx_r <= own_wdata;
        end
    end

    // Bus writes only happen while idle, engine result only while busy
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_r <= `PMA_RST_WORD;
        end else if (done_r && kind_cmd_r && !kind_wr_r && !ta_err_r) begin
            data_r <= rx_r;
        end else if (mgmt_wr && own_addr == `PMA_OFS_DATA_LO) begin
            data_r[7:0] <= own_wdata;
        end else if (mgmt_wr && own_addr == `PMA_OFS_DATA_HI) begin
            data_r[15:8] <= own_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command, error flags

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_r <= `PMA_CMD_IDLE;
        end else if (done_r && kind_cmd_r) begin
            cmd_r <= `PMA_CMD_IDLE;
        end else if (cmd_issue) begin
            if (cmd_code == `PMA_CMD_READ ||
                (cmd_code == `PMA_CMD_WRITE && wr_en_eff))
                cmd_r <= cmd_code;
        end
    end

    // Read error: engine set wins over a same-cycle register write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_err_r <= 1'b0;
        end else if (done_r && kind_cmd_r && !kind_wr_r && ta_err_r) begin
            rd_err_r <= 1'b1;
        end else if (mgmt_wr && (own_addr == `PMA_OFS_CTRL_LO ||
                                 own_addr == `PMA_OFS_CTRL_HI)) begin
            rd_err_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_err_r <= 1'b0;
        end else if (cmd_issue) begin
            unique case (cmd_code)
                `PMA_CMD_IDLE:  cmd_err_r <= 1'b0;
                `PMA_CMD_READ:  cmd_err_r <= 1'b0;
                `PMA_CMD_WRITE: cmd_err_r <= !wr_en_eff;
                default:        cmd_err_r <= 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link poll scheduling

    // Timer keeps counting while a poll waits, the due flag holds it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            poll_tmr_r  <= 32'h0000_0000;
            poll_due_r  <= 1'b0;
            poll_port_r <= '0;
        end else begin
            if (poll_tmr_r >= 32'(POLL_CYCLES - 1)) begin
                poll_tmr_r <= 32'h0000_0000;
                poll_due_r <= 1'b1;
            end else begin
                poll_tmr_r <= poll_tmr_r + 32'h0000_0001;
            end
            if (eng_start_poll) begin
                poll_due_r <= 1'b0;
                poll_port_r <= (poll_port_r == PW'(NPORT - 1)) ?
                               '0 : poll_port_r + PW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Management frame engine

    // Frame: preamble, start, opcode, phy, register, turnaround, data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= PMA_IDLE;
            kind_cmd_r  <= 1'b0;
            kind_wr_r   <= 1'b0;
            kind_port_r <= '0;
            div_r       <= 8'h00;
            mdc_r       <= 1'b0;
            bit_r       <= 6'h00;
            tx_r        <= 64'h0;
            oe_r        <= 1'b0;
            done_r      <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (state_r)
                PMA_IDLE: begin
                    div_r <= 8'h00;
                    mdc_r <= 1'b0;
                    bit_r <= 6'h00;
                    if (eng_start_cmd) begin
                        state_r     <= PMA_RUN;
                        kind_cmd_r  <= 1'b1;
                        kind_wr_r   <= (cmd_r == `PMA_CMD_WRITE);
                        oe_r        <= 1'b1;
                        tx_r <= {32'hffff_ffff, 2'b01,
                                 (cmd_r == `PMA_CMD_WRITE) ?
                                     2'b01 : 2'b10,
                                 target_phy, reg_idx_r[4:0],
                                 2'b10, data_r};
                    end else if (eng_start_poll) begin
                        state_r     <= PMA_RUN;
                        kind_cmd_r  <= 1'b0;
                        kind_wr_r   <= 1'b0;
                        kind_port_r <= poll_port_r;
                        oe_r        <= 1'b1;
                        tx_r <= {32'hffff_ffff, 2'b01, 2'b10,
                                 5'(port0_phy_addr + 5'(poll_port_r)),
                                 `PMA_STATUS_REG, 2'b10, 16'h0000};
                    end
                end
                PMA_RUN: begin
                    div_r <= mdc_tick ? 8'h00 : div_r + 8'h01;
                    if (mdc_tick) begin
                        mdc_r <= ~mdc_r;
                        // Falling edge moves to the next bit slot
                        if (mdc_r) begin
                            if (bit_r == `PMA_FRAME_LAST) begin
                                state_r <= PMA_IDLE;
                                oe_r    <= 1'b0;
                                done_r  <= 1'b1;
                            end else begin
                                bit_r <= bit_r + 6'h01;
                                tx_r  <= {tx_r[62:0], 1'b0};
                                if (!kind_wr_r &&
                                    bit_r + 6'h01 == `PMA_TA_FIRST)
                                    oe_r <= 1'b0;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Sample the transceiver on the rising management clock edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_r     <= 16'h0000;
            ta_err_r <= 1'b0;
        end else if (state_r == PMA_IDLE) begin
            ta_err_r <= (eng_start_cmd || eng_start_poll) ? 1'b0 : ta_err_r;
        end else if (mdc_tick && !mdc_r && !kind_wr_r) begin
            // Absent transceiver leaves the line pulled high here
            if (bit_r == `PMA_TA_LAST && mdio_i)
                ta_err_r <= 1'b1;
            if (bit_r >= `PMA_DATA_FIRST)
                rx_r <= {rx_r[14:0], mdio_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port status from link polls

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_phys_r  <= '0;
            st_ok_r    <= '0;
            st_err_r   <= '0;
            st_rderr_r <= '0;
        end else begin
            if (stat_wr)
                st_rderr_r <= '0;
            if (done_r && !kind_cmd_r) begin
                if (ta_err_r) begin
                    st_rderr_r[kind_port_r] <= 1'b1;
                end else begin
                    st_phys_r[kind_port_r] <= rx_r[2];
                    // Status bit 14 is 100FD ability, bit 5 autoneg done
                    st_ok_r[kind_port_r] <= rx_r[2] & rx_r[5] &
                                            rx_r[14];
                    st_err_r[kind_port_r] <= rx_r[2] &
                                             ~(rx_r[5] & rx_r[14]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign mdc               = mdc_r;
    assign mdio_o            = tx_r[63];
    assign mdio_oe           = oe_r;
    assign port_link_up      = st_ok_r;
    assign port_link_inhibit = st_err_r;

endmodule : pma_top

`default_nettype wire

// >>> sim/pma_top_properties.sv
`default_nettype none
module pma_top_properties #(
    parameter int NPORT = 4
) (
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic             fm_rd,
    input wire logic [11:0]      fm_addr,
    input wire logic [7:0]       fm_rdata,
    input wire logic             lh_rd,
    input wire logic [11:0]      lh_addr,
    input wire logic [7:0]       lh_rdata,
    input wire logic             host_ctrl_allowed,
    input wire logic             link_detect_en,
    input wire logic             mdc,
    input wire logic             mdio_o,
    input wire logic             mdio_oe,
    input wire logic [NPORT-1:0] port_link_up,
    input wire logic [NPORT-1:0] port_link_inhibit
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Status byte reads tie to the live inputs and flags
    property p_cap;
        fm_rd && fm_addr == 12'h510 |=>
            fm_rdata[1] == $past(host_ctrl_allowed);
    endproperty
    a_cap: assert property (p_cap) else $error("host cap bit");
    property p_det;
        lh_rd && lh_addr == 12'h510 |=> lh_rdata[2] == $past(link_detect_en);
    endproperty
    a_det: assert property (p_det) else $error("detect bit");
    property p_up;
        fm_rd && fm_addr == 12'h518 |=> fm_rdata[1] == $past(port_link_up[0]);
    endproperty
    a_up: assert property (p_up) else $error("link up bit");
    property p_inh;
        fm_rd && fm_addr == 12'h518 |=>
            fm_rdata[2] == $past(port_link_inhibit[0]);
    endproperty
    a_inh: assert property (p_inh) else $error("inhibit bit");
    // A usable link and an inhibited link exclude each other
    property p_excl;
        (port_link_up & port_link_inhibit) == '0;
    endproperty
    a_excl: assert property (p_excl) else $error("up and inhibit");
    // Each clock half is four system clocks
    property p_hi;
        $rose(mdc) |-> mdc [*4] ##1 !mdc;
    endproperty
    a_hi: assert property (p_hi) else $error("mdc high half");
    property p_lo;
        $fell(mdc) |-> !mdc [*4];
    endproperty
    a_lo: assert property (p_lo) else $error("mdc low half");
    // Data moves only while the clock is low, away from sampling
    property p_edge;
        $changed(mdio_o) && mdio_oe |-> !mdc;
    endproperty
    a_edge: assert property (p_edge) else $error("mdio edge");
    c_frame: cover property ($rose(mdio_oe));
    c_up: cover property (port_link_up[0]);
    c_inh: cover property (port_link_inhibit[0]);
endmodule // pma_top_properties
bind pma_top pma_top_properties #(.NPORT(NPORT)) u_props (.clk, .resetn,
    .fm_rd, .fm_addr, .fm_rdata, .lh_rd, .lh_addr, .lh_rdata,
    .host_ctrl_allowed, .link_detect_en, .mdc, .mdio_o, .mdio_oe,
    .port_link_up, .port_link_inhibit);
`default_nettype wire

// >>> sim/pma_phy_model.sv
`default_nettype none
module pma_phy_model (
    input  wire logic        mdc,
    input  wire logic        mdio_o,
    input  wire logic        mdio_oe,
    input  wire logic        absent,
    input  wire logic [15:0] stat,
    output logic             mdio_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] regs [32];
    logic [15:0] sr = 16'h0000;
    logic [4:0]  idx = 5'h00;
    logic        drv = 1'b0;
    logic        dbit = 1'b0;
    logic        rd_op = 1'b0;
    logic        got0 = 1'b0;
    int          ones = 0;
    int          n = -1;
    // Released line rests at the pull-up level
    assign mdio_line = mdio_oe ? mdio_o : (drv ? dbit : 1'b1);
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 16'h5a00 + 16'(i);
        end
    end
    // Preamble hunt, header decode and write capture on rising clock
    always @(posedge mdc) begin
        sr <= {sr[14:0], mdio_line};
        if (n >= 0) begin
            n <= (n == 29) ? -1 : n + 1;
            if (n == 1) rd_op <= sr[0] & !mdio_line;
            if (n == 11) idx <= {sr[3:0], mdio_line};
            if (n == 29 && !rd_op) regs[idx] <= {sr[14:0], mdio_line};
        end else if (!got0) begin
            ones <= mdio_line ? ones + 1 : 0;
            got0 <= !mdio_line && ones >= 32;
        end else begin
            got0 <= 1'b0;
            ones <= 0;
            n <= mdio_line ? 0 : -1;
        end
    end
    // Reply after falling clock; an absent device leaves turnaround high
    always @(negedge mdc) begin
        drv <= rd_op && !absent && n >= 13 && n <= 29;
        dbit <= (n == 13) ? 1'b0 : (idx == 5'h01) ? stat[29 - n] :
            regs[idx][29 - n];
    end
endmodule // pma_phy_model
`default_nettype wire

// >>> sim/test_pma_top.sv
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    num_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module test_pma_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, resetn = 1'b0, frame_start = 1'b0, absent = 1'b0;
    logic        fm_wr = 1'b0, fm_rd = 1'b0, lh_wr = 1'b0, lh_rd = 1'b0;
    logic        host_ctrl_allowed = 1'b1, link_detect_en = 1'b0;
    logic        mdc, mdio_o, mdio_oe, mdio_line;
    logic [11:0] fm_addr = 12'h000, lh_addr = 12'h000;
    logic [7:0]  fm_wdata = 8'h00, lh_wdata = 8'h00, fm_rdata, lh_rdata, rq;
    logic [15:0] stat = 16'h0000;
    logic [3:0]  port_link_up, port_link_inhibit;
    int          num_errors = 0, samples_checked = 0;
    pma_top #(.NPORT(4), .POLL_CYCLES(600)) u_dut (.clk, .resetn, .fm_wr,
        .fm_rd, .fm_addr, .fm_wdata, .fm_rdata, .lh_wr, .lh_rd, .lh_addr,
        .lh_wdata, .lh_rdata, .frame_start, .host_ctrl_allowed,
        .link_detect_en, .port0_phy_addr(5'h04), .mdc, .mdio_i(mdio_line),
        .mdio_o, .mdio_oe, .port_link_up, .port_link_inhibit);
    pma_phy_model u_phy (.mdc, .mdio_o, .mdio_oe, .absent, .stat, .mdio_line);
    // 20 MHz system clock
    initial begin
        forever #25 clk = ~clk;
    end
    // One byte access; strobe lives for a single clock
    task automatic acc(input bit s, input bit w, input logic [11:0] a,
                       input logic [7:0] d);
        @(negedge clk);
        {fm_wr, fm_rd, lh_wr, lh_rd} = {w & !s, !w & !s, w & s, !w & s};
        {fm_addr, lh_addr, fm_wdata, lh_wdata} = {a, a, d, d};
        @(negedge clk);
        {fm_wr, fm_rd, lh_wr, lh_rd} = 4'h0;
        rq = s ? lh_rdata : fm_rdata;
    endtask
    task automatic chk(input bit s, input logic [11:0] a, input logic [7:0] e);
        acc(s, 1'b0, a, 8'h00);
        `CHK(rq, e)
    endtask
    // Poll busy under a bound; a hang is caught by a later compare
    task automatic run(input bit s, input logic [7:0] c);
        if (c != 8'h00) acc(s, 1'b1, 12'h511, c);
        rq = 8'h80;
        for (int i = 0; i < 700 && rq[7] !== 1'b0; i++)
            acc(s, 1'b0, 12'h511, 8'h00);
    endtask
    task automatic finish_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Watchdog, well past the expected run
    initial begin
        #2000000;
        num_errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        for (int a = 'h511; a < 'h518; a++) chk(0, 12'(a), 8'h00);
        chk(0, 12'h51c, 8'h00);
        chk(0, 12'h510, 8'h22);
        acc(0, 1'b1, 12'h512, 8'h82);
        chk(0, 12'h510, 8'h32);
        acc(0, 1'b1, 12'h512, 8'h01);
        acc(0, 1'b1, 12'h511, 8'h02);
        chk(0, 12'h511, 8'h40);
        acc(0, 1'b1, 12'h511, 8'h00);
        chk(0, 12'h511, 8'h00);
        acc(0, 1'b1, 12'h511, 8'h03);
        chk(0, 12'h511, 8'h40);
        acc(0, 1'b1, 12'h513, 8'h02);
        acc(0, 1'b1, 12'h511, 8'h01);
        chk(0, 12'h511, 8'h81);
        acc(0, 1'b1, 12'h513, 8'h1f);
        run(0, 8'h00);
        chk(0, 12'h511, 8'h00);
        chk(0, 12'h513, 8'h02);
        chk(0, 12'h514, 8'h02);
        chk(0, 12'h515, 8'h5a);
        acc(0, 1'b1, 12'h510, 8'h01);
        acc(0, 1'b1, 12'h514, 8'h34);
        acc(0, 1'b1, 12'h515, 8'h12);
        acc(0, 1'b1, 12'h513, 8'h05);
        run(0, 8'h02);
        `CHK(u_phy.regs[5], 16'h1234)
        acc(0, 1'b1, 12'h510, 8'h01);
        chk(0, 12'h510, 8'h23);
        @(negedge clk) frame_start = 1'b1;
        @(negedge clk) frame_start = 1'b0;
        chk(0, 12'h510, 8'h22);
        absent = 1'b1;
        run(0, 8'h01);
        chk(0, 12'h511, 8'h20);
        acc(0, 1'b1, 12'h511, 8'h00);
        chk(0, 12'h511, 8'h00);
        absent = 1'b0;
        acc(1, 1'b1, 12'h517, 8'h01);
        chk(0, 12'h510, 8'h23);
        acc(0, 1'b1, 12'h511, 8'h01);
        chk(0, 12'h511, 8'h00);
        run(1, 8'h01);
        chk(1, 12'h514, 8'h34);
        acc(0, 1'b1, 12'h516, 8'h01);
        chk(0, 12'h516, 8'h00);
        acc(0, 1'b1, 12'h517, 8'h02);
        chk(0, 12'h517, 8'h00);
        acc(0, 1'b1, 12'h516, 8'h01);
        chk(0, 12'h516, 8'h01);
        acc(1, 1'b1, 12'h517, 8'h01);
        chk(0, 12'h517, 8'h00);
        acc(0, 1'b1, 12'h516, 8'h00);
        stat = 16'h4024;
        link_detect_en = 1'b1;
        chk(1, 12'h510, 8'h26);
        repeat (3000) @(negedge clk);
        chk(0, 12'h518, 8'h03);
        `CHK(port_link_up, 4'hf)
        stat = 16'h0004;
        repeat (3000) @(negedge clk);
        chk(0, 12'h518, 8'h05);
        `CHK(port_link_inhibit, 4'hf)
        absent = 1'b1;
        repeat (3000) @(negedge clk);
        chk(0, 12'h518, 8'h0d);
        absent = 1'b0;
        repeat (3000) @(negedge clk);
        acc(0, 1'b1, 12'h518, 8'h00);
        chk(0, 12'h518, 8'h05);
        host_ctrl_allowed = 1'b0;
        chk(0, 12'h510, 8'h24);
        finish_test();
    end
endmodule // test_pma_top
`default_nettype wire
